// [src/aea_pkg.sv]
/*
  constants for the active energy accumulator: register offsets, field positions,
  reset values and the sample timing.
  assumes a 40 MHz system clock and the 8 kHz power sample rate.
*/
package aea_pkg;
  // register offsets on the register access port
  localparam logic [7:0] ADDR_GAIN_BASE   = 8'h00;
  localparam logic [7:0] ADDR_OFS_BASE    = 8'h06;
  localparam logic [7:0] ADDR_THR_UPPER   = 8'h0c;
  localparam logic [7:0] ADDR_THR_LOWER   = 8'h0d;
  localparam logic [7:0] ADDR_ENERGY_BASE = 8'h0e;
  localparam logic [7:0] ADDR_ACCUMULATION_MODE_REGISTER     = 8'h14;
  localparam logic [7:0] ADDR_LINE_CYCLE_MODE_REGISTER    = 8'h15;
  localparam logic [7:0] ADDR_STATUS      = 8'h16;
  localparam logic [7:0] ADDR_MASK        = 8'h17;
  localparam logic [7:0] ADDR_SIGN        = 8'h18;
  localparam int         NUM_CH           = 6;
  localparam logic [2:0] NO_CH            = 3'h7;
  // field positions
  localparam int REVSEL_BIT    = 6;
  localparam int CONNECTION_SELECT_LSB    = 4;
  localparam int RDCLR_BIT     = 6;
  localparam int HF_TOT_BIT    = 0;
  localparam int HF_FND_BIT    = 1;
  localparam int REV_LSB       = 6;
  localparam int HALF_BIT      = 30;
  // connection select codes
  localparam logic [1:0] CONNECTION_SELECT_ALL   = 2'h0;
  localparam logic [1:0] CONNECTION_SELECT_BZERO = 2'h1;
  localparam logic [1:0] CONNECTION_SELECT_VDER  = 2'h2;
  localparam logic [1:0] CONNECTION_SELECT_VNEGA = 2'h3;
  // reset values
  localparam logic [23:0] GAIN_RST   = 24'h000000;
  localparam logic [23:0] THR_RST    = 24'h000000;
  localparam logic [31:0] ENERGY_RST = 32'h00000000;
  localparam logic [8:0]  STATUS_RST = 9'h000;
  // timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int SAMPLE_HZ     = 8_000;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
endpackage : aea_pkg

// [src/aea_top.sv]
/*
  active power calibration and two stage energy integration for three phases,
  total and fundamental paths, with reversal and half-full status.
  assumes filtered powers arrive synchronous to CLK_SYS_I and are steady
  across the sample strobe; register port strobes are single-cycle.
*/
`timescale 1ns/1ps

// Functional notes
// - power scaled by one plus signed gain over two to twenty-three.
// - gain c00000 halves the power, 400000 raises it by half.
// - gain and offset read as 32 bits, top nibble zero, sign-extended to 28.
// - signed offset added to each phase power, one unit per multiplier unit.
// - accumulation mode bit 6 picks total or fundamental for reversal.
// - threshold crossing with changed sign sets the phase reversal flag.
// - sign bits updated together with the reversal flag, one means negative.
// - masked reversal flags pull the interrupt request low.
// - writing one clears a status bit, zero leaves it.
// - every sample add power; on threshold emit pulse and subtract threshold.
// - pulses counted in 32-bit counters, handed over when registers accessed.
// - negative pulses decrement, positive pulses increment energy.
// - threshold reached as two words of 24 bits, top byte zero.
// - energy counters wrap in both directions and keep counting.
// - bit 30 toggle sets total or fundamental half-full status.
// - mask bits 1 and 0 enable the half-full flags onto the request.
// - with read-clear set, an energy read returns value then clears it.
// - accumulation mode bits 5:4 choose the products feeding phase b.
// - codes 00 all phases, 01 phase b zero, 10 derived phase b voltage, 11 the VNEGA phase b inputs.
module aea_top
  import aea_pkg::*;
#(
  parameter int SAMPLE_DIV = aea_pkg::SAMPLE_CYCLES
)
(
  // clock and reset
  input  wire logic                    CLK_SYS_I,
  input  wire logic                    SYS_RST_I,
  // filtered powers, phases c..a
  input  wire logic [2:0][27:0]        PWR_TOT_I,
  input  wire logic [2:0][27:0]        PWR_FND_I,
  input  wire logic [27:0]             PWR_B_TOT_VDER_I,
  input  wire logic [27:0]             PWR_B_TOT_VNEGA_I,
  input  wire logic [27:0]             PWR_B_FND_VDER_I,
  input  wire logic [27:0]             PWR_B_FND_VNEGA_I,
  // register access port
  input  wire logic [7:0]              REG_ADDR_I,
  input  wire logic                    REG_WR_I,
  input  wire logic                    REG_RD_I,
  input  wire logic [31:0]             REG_WDATA_I,
  output logic      [31:0]             REG_RDATA_O,
  // interrupt and energy pulses
  output logic                         INTERRUPT_REQUEST_N_O,
  output logic      [5:0]              ENERGY_PULSE_O
);
  import aea_pkg::*;

  function automatic logic [2:0] reg_idx(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] d;
    d = addr - base;
    reg_idx = (addr >= base && d < 8'(NUM_CH)) ? d[2:0] : NO_CH;
  endfunction : reg_idx

  logic        [15:0] div_cnt;
  logic               sample_en;
  logic signed [23:0] gain [NUM_CH];
  logic signed [23:0] ofs  [NUM_CH];
  logic        [23:0] thr_upper;
  logic        [23:0] thr_lower;
  logic        [6:0]  acc_mode;
  logic        [6:0]  lcyc_mode;
  logic        [8:0]  status;
  logic        [8:0]  mask;
  logic        [2:0]  power_sign;
  logic signed [48:0] acc1 [NUM_CH];
  logic        [31:0] energy [NUM_CH];
  logic signed [27:0] p_in   [NUM_CH];
  logic signed [47:0] scaled [NUM_CH];
  logic signed [51:0] prod   [NUM_CH];
  logic signed [48:0] next_acc1 [NUM_CH];
  logic        [31:0] next_energy [NUM_CH];
  logic        [5:0]  pulse_p;
  logic        [5:0]  pulse_n;
  logic        [5:0]  hf_tog;
  logic        [2:0]  rev_set;
  logic        [2:0]  next_sign;
  logic        [8:0]  next_status;
  logic        [2:0]  wr_gain;
  logic        [2:0]  wr_ofs;
  logic        [2:0]  rd_energy;
  logic signed [48:0] thr_s;

  assign wr_gain   = REG_WR_I ? reg_idx(REG_ADDR_I, ADDR_GAIN_BASE) : NO_CH;
  assign wr_ofs    = REG_WR_I ? reg_idx(REG_ADDR_I, ADDR_OFS_BASE) : NO_CH;
  assign rd_energy = REG_RD_I ? reg_idx(REG_ADDR_I, ADDR_ENERGY_BASE) : NO_CH;
  assign thr_s     = {1'b0, thr_upper, thr_lower};

  // 8 kHz sample strobe
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      div_cnt   <= 16'h0000;
      sample_en <= 1'b0;
    end
    else if (div_cnt == 16'(SAMPLE_DIV - 1))
    begin
      div_cnt   <= 16'h0000;
      sample_en <= 1'b1;
    end
    else
    begin
      div_cnt   <= div_cnt + 16'h0001;
      sample_en <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        gain[i] <= GAIN_RST;
        ofs[i]  <= GAIN_RST;
      end
      thr_upper <= THR_RST;
      thr_lower <= THR_RST;
      acc_mode  <= 7'h00;
      lcyc_mode <= 7'h00;
      mask      <= STATUS_RST;
    end
    else if (REG_WR_I)
    begin
      if (wr_gain != NO_CH)
        gain[wr_gain] <= REG_WDATA_I[23:0];
      if (wr_ofs != NO_CH)
        ofs[wr_ofs] <= REG_WDATA_I[23:0];
      case (REG_ADDR_I)
        ADDR_THR_UPPER: thr_upper <= REG_WDATA_I[23:0];
        ADDR_THR_LOWER: thr_lower <= REG_WDATA_I[23:0];
        ADDR_ACCUMULATION_MODE_REGISTER:   acc_mode  <= REG_WDATA_I[6:0];
        ADDR_LINE_CYCLE_MODE_REGISTER:  lcyc_mode <= REG_WDATA_I[6:0];
        ADDR_MASK:      mask      <= REG_WDATA_I[8:0];
        default:        mask      <= mask;
      endcase
    end
  end

  // input select, calibration and first stage arithmetic
  always_comb
  begin
    for (int ph = 0; ph < 3; ph++)
    begin
      p_in[ph]     = PWR_TOT_I[ph];
      p_in[ph + 3] = PWR_FND_I[ph];
    end
    case (acc_mode[CONNECTION_SELECT_LSB +: 2])
      CONNECTION_SELECT_BZERO:
      begin
        p_in[1] = 28'h0000000;
        p_in[4] = 28'h0000000;
      end
      CONNECTION_SELECT_VDER:
      begin
        p_in[1] = PWR_B_TOT_VDER_I;
        p_in[4] = PWR_B_FND_VDER_I;
      end
      CONNECTION_SELECT_VNEGA:
      begin
        p_in[1] = PWR_B_TOT_VNEGA_I;
        p_in[4] = PWR_B_FND_VNEGA_I;
      end
      default:
      begin
        p_in[1] = PWR_TOT_I[1];
        p_in[4] = PWR_FND_I[1];
      end
    endcase
    for (int i = 0; i < NUM_CH; i++)
    begin
      // p + p*g/2^23 + offset, 52-bit product keeps full precision
      prod[i]   = 52'(p_in[i]) * 52'(gain[i]);
      scaled[i] = 48'(p_in[i]) + 48'(prod[i] >>> 23) + 48'(ofs[i]);
      next_acc1[i] = acc1[i] + 49'(scaled[i]);
      pulse_p[i] = 1'b0;
      pulse_n[i] = 1'b0;
      if (sample_en && next_acc1[i] >= thr_s)
      begin
        pulse_p[i]   = 1'b1;
        next_acc1[i] = next_acc1[i] - thr_s;
      end
      else if (sample_en && next_acc1[i] <= -thr_s)
      begin
        pulse_n[i]   = 1'b1;
        next_acc1[i] = next_acc1[i] + thr_s;
      end
    end
  end

  // first stage accumulators; a zero threshold pulses on every sample
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      for (int i = 0; i < NUM_CH; i++)
        acc1[i] <= 49'h0;
      ENERGY_PULSE_O <= 6'h00;
    end
    else
    begin
      if (sample_en)
        for (int i = 0; i < NUM_CH; i++)
          acc1[i] <= next_acc1[i];
      ENERGY_PULSE_O <= pulse_p | pulse_n;
    end
  end

  // second stage counters
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      next_energy[i] = (rd_energy == 3'(i) && lcyc_mode[RDCLR_BIT]) ? ENERGY_RST : energy[i];
      if (pulse_p[i])
        next_energy[i] = next_energy[i] + 32'h00000001;
      else if (pulse_n[i])
        next_energy[i] = next_energy[i] - 32'h00000001;
      hf_tog[i] = (pulse_p[i] | pulse_n[i]) &&
                  (next_energy[i][HALF_BIT] != ((rd_energy == 3'(i) && lcyc_mode[RDCLR_BIT]) ?
                   1'b0 : energy[i][HALF_BIT]));
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      for (int i = 0; i < NUM_CH; i++)
        energy[i] <= ENERGY_RST;
    else
      for (int i = 0; i < NUM_CH; i++)
        energy[i] <= next_energy[i];
  end

  // reversal detection on the selected power type
  always_comb
  begin
    next_sign = power_sign;
    for (int ph = 0; ph < 3; ph++)
    begin
      rev_set[ph] = 1'b0;
      if (acc_mode[REVSEL_BIT] ? (pulse_p[ph + 3] | pulse_n[ph + 3]) : (pulse_p[ph] | pulse_n[ph]))
      begin
        next_sign[ph] = acc_mode[REVSEL_BIT] ? pulse_n[ph + 3] : pulse_n[ph];
        rev_set[ph]   = next_sign[ph] != power_sign[ph];
      end
    end
  end

  // status: hardware set wins over a same-cycle write-one clear
  always_comb
  begin
    next_status = status;
    if (REG_WR_I && REG_ADDR_I == ADDR_STATUS)
      next_status = status & ~REG_WDATA_I[8:0];
    next_status[HF_TOT_BIT] = next_status[HF_TOT_BIT] | (|hf_tog[2:0]);
    next_status[HF_FND_BIT] = next_status[HF_FND_BIT] | (|hf_tog[5:3]);
    next_status[REV_LSB +: 3] = next_status[REV_LSB +: 3] | rev_set;
    next_status[5:2] = 4'h0;
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      status     <= STATUS_RST;
      power_sign <= 3'h0;
    end
    else
    begin
      status     <= next_status;
      power_sign <= next_sign;
    end
  end

  // one cycle behind status; the pin falls on the same edge as the earliest read data showing the flag
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      INTERRUPT_REQUEST_N_O <= 1'b1;
    else
      INTERRUPT_REQUEST_N_O <= ~|(status & mask);
  end

  // read data, energy reads hand over the live counter
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      REG_RDATA_O <= 32'h00000000;
    else if (REG_RD_I)
    begin
      if (reg_idx(REG_ADDR_I, ADDR_GAIN_BASE) != NO_CH)
        REG_RDATA_O <= {4'h0, 28'(gain[reg_idx(REG_ADDR_I, ADDR_GAIN_BASE)])};
      else if (reg_idx(REG_ADDR_I, ADDR_OFS_BASE) != NO_CH)
        REG_RDATA_O <= {4'h0, 28'(ofs[reg_idx(REG_ADDR_I, ADDR_OFS_BASE)])};
      else if (rd_energy != NO_CH)
        REG_RDATA_O <= energy[rd_energy];
      else
        case (REG_ADDR_I)
          ADDR_THR_UPPER: REG_RDATA_O <= {8'h00, thr_upper};
          ADDR_THR_LOWER: REG_RDATA_O <= {8'h00, thr_lower};
          ADDR_ACCUMULATION_MODE_REGISTER:   REG_RDATA_O <= {25'h0, acc_mode};
          ADDR_LINE_CYCLE_MODE_REGISTER:  REG_RDATA_O <= {25'h0, lcyc_mode};
          ADDR_STATUS:    REG_RDATA_O <= {23'h0, status};
          ADDR_MASK:      REG_RDATA_O <= {23'h0, mask};
          ADDR_SIGN:      REG_RDATA_O <= {29'h0, power_sign};
          default:        REG_RDATA_O <= 32'h00000000;
        endcase
    end
  end

  property p_unity_gain;
    @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (gain[0] == 24'h000000 && ofs[0] == 24'h000000) |-> scaled[0] == 48'(p_in[0]);
  endproperty
  a_unity_gain: assert property (p_unity_gain) else $error("unity gain changes power");

  property p_half_gain;
    @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (gain[0] == 24'hc00000 && ofs[0] == 24'h000000 && !p_in[0][0]) |-> scaled[0] == 48'(p_in[0] >>> 1);
  endproperty
  a_half_gain: assert property (p_half_gain) else $error("gain c00000 does not halve");

  sequence s_read_gain0;
    REG_RD_I && REG_ADDR_I == ADDR_GAIN_BASE;
  endsequence
  property p_gain_readback;
    @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      s_read_gain0 |=> REG_RDATA_O == {4'h0, {4{$past(gain[0][23])}}, $past(gain[0])};
  endproperty
  a_gain_readback: assert property (p_gain_readback) else $error("gain readback not sign-extended");

  property p_reversal;
    @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      rev_set[0] |=> status[REV_LSB] && power_sign[0] != $past(power_sign[0]);
  endproperty
  a_reversal: assert property (p_reversal) else $error("reversal flag or sign missing");

  property p_irq_low;
    @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (|(status & mask)) |=> !INTERRUPT_REQUEST_N_O;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("request not low for enabled flag");

  property p_w1c;
    @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (REG_WR_I && REG_ADDR_I == ADDR_STATUS && REG_WDATA_I[REV_LSB] && !rev_set[0]) |=> !status[REV_LSB];
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared by one");

  property p_pulse_on_sample;
    @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (|(pulse_p | pulse_n)) |-> sample_en;
  endproperty
  a_pulse_on_sample: assert property (p_pulse_on_sample) else $error("pulse outside sample");

  property p_count_up;
    @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (pulse_p[0] && rd_energy != 3'h0) |=> energy[0] == $past(energy[0]) + 32'h00000001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("positive pulse not counted");

  property p_read_clear;
    @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      (rd_energy == 3'h0 && lcyc_mode[RDCLR_BIT] && !pulse_p[0] && !pulse_n[0]) |=>
        energy[0] == ENERGY_RST && REG_RDATA_O == $past(energy[0]);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read-clear failed");

endmodule : aea_top

// [sim/aea_host.sv]
/*
  host model: register master on the block's register port.
  assumes single-cycle strobes launched just after a rising clock edge.
*/
`timescale 1ns/1ps
module aea_host
  import aea_pkg::*;
(
  // clock
  input  wire logic        clk_i,
  // register port
  input  wire logic [31:0] rdata_i,
  output logic      [7:0]  addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [31:0] wdata_o
);
  initial
  begin
    addr_o  = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 32'h00000000;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    // idle bus shows junk, not the last word
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd_reg

  // sign read straight after status; clearing is left to the caller
  task automatic service_reversal(output logic [31:0] st, output logic [31:0] sg);
    rd_reg(ADDR_STATUS, st);
    rd_reg(ADDR_SIGN, sg);
  endtask : service_reversal

  // 47-bit argument keeps the threshold non-negative
  task automatic set_threshold(input logic [46:0] t);
    // lower word first: no zero threshold between the two writes unless the old upper and new lower words are both zero
    wr_reg(ADDR_THR_LOWER, {8'h00, t[23:0]});
    wr_reg(ADDR_THR_UPPER, {8'h00, 1'b0, t[46:24]});
  endtask : set_threshold
endmodule : aea_host

// [sim/aea_top_bench.sv]
/*
  self-checking bench for aea_top: register port, gain and offset, pulse rate,
  signed energy with read-clear, reversal status, request and connection select.
  assumes aea_host as register master; sample divider shortened to 8 cycles.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module aea_top_bench;
  import aea_pkg::*;
  logic             clk_sys;
  logic             sys_rst;
  logic [2:0][27:0] pwr_tot;
  logic [2:0][27:0] pwr_fnd;
  logic [27:0]      b_tot_vder;
  logic [27:0]      b_tot_vnega;
  logic [7:0]       reg_addr;
  logic             reg_wr;
  logic             reg_rd;
  logic [31:0]      reg_wdata;
  logic [31:0]      reg_rdata;
  logic             irq_n;
  logic [5:0]       pulse;
  logic [31:0]      rv;
  logic [31:0]      sv;
  int               n;
  int               errors = 0;
  int               total_checks = 0;
  int               cycles = 0;

  aea_top #(.SAMPLE_DIV(8)) u_aea_top (
    .CLK_SYS_I(clk_sys), .SYS_RST_I(sys_rst), .PWR_TOT_I(pwr_tot), .PWR_FND_I(pwr_fnd),
    .PWR_B_TOT_VDER_I(b_tot_vder), .PWR_B_TOT_VNEGA_I(b_tot_vnega),
    .PWR_B_FND_VDER_I(28'h0000000), .PWR_B_FND_VNEGA_I(28'h0000000),
    .REG_ADDR_I(reg_addr), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_WDATA_I(reg_wdata),
    .REG_RDATA_O(reg_rdata), .INTERRUPT_REQUEST_N_O(irq_n), .ENERGY_PULSE_O(pulse));

  aea_host u_aea_host (
    .clk_i(clk_sys), .rdata_i(reg_rdata), .addr_o(reg_addr), .wr_o(reg_wr),
    .rd_o(reg_rd), .wdata_o(reg_wdata));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ceiling well above the under two thousand cycles the tests need
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      test_done;
    end
  end

  task automatic wait_pulse(input int ch, output int k);
    k = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    while (pulse[ch] !== 1'b1 && k < 120);
  endtask : wait_pulse

  // third spacing only: the first two may carry old accumulator residue
  task automatic gap(input int ch, output int k);
    repeat (3) wait_pulse(ch, k);
    if (k >= 120)
      k = 0;
  endtask : gap

  task automatic energy3(input logic [31:0] e);
    wait_pulse(0, n);
    u_aea_host.rd_reg(ADDR_ENERGY_BASE, rv);
    repeat (3) wait_pulse(0, n);
    u_aea_host.rd_reg(ADDR_ENERGY_BASE, rv);
    `CHK("energy phase a", e, rv)
  endtask : energy3

  task automatic t_regs;
    u_aea_host.rd_reg(ADDR_STATUS, rv);
    `CHK("status at reset", 32'h00000000, rv)
    u_aea_host.wr_reg(ADDR_GAIN_BASE, 32'hffc00000);
    u_aea_host.rd_reg(ADDR_GAIN_BASE, rv);
    `CHK("gain word", 32'h0fc00000, rv)
    u_aea_host.wr_reg(ADDR_THR_UPPER, 32'hffabcdef);
    u_aea_host.rd_reg(ADDR_THR_UPPER, rv);
    `CHK("threshold upper", 32'h00abcdef, rv)
    // huge threshold first: the small negative offset leaves no pulses, only a small residue
    u_aea_host.wr_reg(ADDR_OFS_BASE + 8'h04, 32'h00ffffff);
    u_aea_host.rd_reg(ADDR_OFS_BASE + 8'h04, rv);
    `CHK("offset word", 32'h0fffffff, rv)
    u_aea_host.rd_reg(8'h40, rv);
    `CHK("unmapped read", 32'h00000000, rv)
    u_aea_host.wr_reg(ADDR_GAIN_BASE, 32'h00000000);
    u_aea_host.wr_reg(ADDR_OFS_BASE + 8'h04, 32'h00000000);
    u_aea_host.set_threshold(47'h00000000012c);
    $display("test regs done");
  endtask : t_regs

  task automatic t_cal;
    logic [31:0] g [4];
    int          e [4];
    g = '{32'h00000000, 32'h00400000, 32'h00c00000, 32'h00000000};
    e = '{16, 16, 48, 24};
    @(posedge clk_sys);
    pwr_tot[0] <= 28'h0000064;
    pwr_fnd[0] <= 28'h0000064;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 4; i++)
      begin
        u_aea_host.wr_reg(ADDR_GAIN_BASE + 8'(3 * p), g[i]);
        u_aea_host.wr_reg(ADDR_OFS_BASE + 8'(3 * p), (i == 0) ? 32'h00000032 : 32'h00000000);
        gap(3 * p, n);
        `CHK("pulse spacing", e[i], n)
      end
    u_aea_host.wr_reg(ADDR_LINE_CYCLE_MODE_REGISTER, 32'h00000040);
    energy3(32'h00000003);
    $display("test calibration and energy done");
  endtask : t_cal

  task automatic t_rev;
    u_aea_host.wr_reg(ADDR_MASK, 32'h000001c0);
    @(posedge clk_sys);
    pwr_tot[0] <= 28'hfffff9c;
    pwr_tot[2] <= 28'hfffff9c;
    wait_pulse(0, n);
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("request low", 1'b0, irq_n)
    wait_pulse(2, n);
    u_aea_host.service_reversal(rv, sv);
    `CHK("reversal flags", 3'b101, rv[8:6])
    `CHK("sign bits", 3'b101, sv[2:0])
    // phase a energy went from zero to negative: bit 30 changed
    `CHK("half-full flags", 2'b01, rv[1:0])
    u_aea_host.wr_reg(ADDR_STATUS, 32'h00000041);
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("request held", 1'b0, irq_n)
    u_aea_host.wr_reg(ADDR_STATUS, 32'h00000100);
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("request released", 1'b1, irq_n)
    u_aea_host.rd_reg(ADDR_STATUS, rv);
    `CHK("status cleared", 32'h00000000, rv)
    energy3(32'hfffffffd);
    $display("test reversal done");
  endtask : t_rev

  task automatic t_connection_select;
    int e [4];
    e = '{24, 0, 16, 48};
    @(posedge clk_sys);
    pwr_tot[1]  <= 28'h0000064;
    b_tot_vder  <= 28'h0000096;
    b_tot_vnega <= 28'h0000032;
    for (int c = 0; c < 4; c++)
    begin
      u_aea_host.wr_reg(ADDR_ACCUMULATION_MODE_REGISTER, 32'(c) << CONNECTION_SELECT_LSB);
      gap(1, n);
      `CHK("phase b spacing", e[c], n)
    end
    // fundamental now watched: phase a fund positive, phase b fund negative
    u_aea_host.wr_reg(ADDR_ACCUMULATION_MODE_REGISTER, 32'h00000040);
    @(posedge clk_sys);
    pwr_fnd[1] <= 28'hfffff9c;
    wait_pulse(4, n);
    wait_pulse(4, n);
    u_aea_host.service_reversal(rv, sv);
    `CHK("fund reversal flags", 3'b011, rv[8:6])
    `CHK("fund sign bits", 3'b110, sv[2:0])
    $display("test connection select done");
  endtask : t_connection_select

  initial
  begin
    sys_rst     = 1'b1;
    pwr_tot     = '0;
    pwr_fnd     = '0;
    b_tot_vder  = 28'h0000000;
    b_tot_vnega = 28'h0000000;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_cal;
    t_rev;
    t_connection_select;
    test_done;
  end
endmodule : aea_top_bench
